// ==== design/cis_defines.vh ====
// Offsets, field positions, reset values and sizes of the interrupt sequencer
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH

`define CIS_NSRC 8
`define CIS_NEXT 5
`define CIS_PRIO_W 24

// Register byte addresses
`define CIS_OFF_FLAG 5'h00
`define CIS_OFF_ENABLE 5'h04
`define CIS_OFF_PRIO 5'h08
`define CIS_OFF_CTRL1 5'h0C
`define CIS_OFF_CTRL2 5'h10
`define CIS_OFF_STATUS 5'h14
`define CIS_OFF_CORE 5'h18
`define CIS_OFF_SEQ 5'h1C

// Field positions
`define CIS_NEST_DIS_BIT 15
`define CIS_MSB_BIT 3
`define CIS_IPL_HI 7
`define CIS_IPL_LO 5

// Reset values
`define CIS_FLAG_RST 8'h00
`define CIS_ENABLE_RST 8'h00
`define CIS_PRIO_RST 24'h000000
`define CIS_SRL_RST 8'h00
`define CIS_POL_RST 5'h00

// Levels and vectors
`define CIS_IPL_MAX 3'h7
`define CIS_VEC_BASE 24'h000100

`endif

// ==== design/cis_edge_detect.v ====
// Edge detector with selectable polarity for one external interrupt pin
`timescale 1ns/100ps
module cis_edge_detect
(
  input wire core_clk,
  input wire reset,
  input wire core_ce,
  input wire pin,
  input wire falling,
  output wire edge_seen
);

reg prev_r;

always @(posedge core_clk)
begin
  // Start from the pin level so leaving reset shows no false edge
  if (reset)
    prev_r <= pin;
  else if (core_ce)
    prev_r <= pin;
end

// Polarity bit set selects the falling edge
assign edge_seen = falling ? (prev_r & ~pin) : (~prev_r & pin);

endmodule // cis_edge_detect

// ==== design/cis_top.v ====
// Interrupt controller and interrupt entry / return sequencer
`timescale 1ns/100ps
`include "cis_defines.vh"
module cis_top
(
  input wire core_clk,
  input wire reset,
  input wire core_ce,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Event sources
  input wire [`CIS_NEXT-1:0] ext_int_pin,
  input wire [`CIS_NSRC-`CIS_NEXT-1:0] periph_event,
  // Processor core side
  input wire [23:0] cpu_pc,
  input wire cpu_sleep,
  input wire ret_start,
  input wire [15:0] pop_data,
  output reg wake_r,
  output reg resume_r,
  output reg forced_no_operation_r,
  output reg push_valid_r,
  output reg [15:0] push_data_r,
  output reg vector_load_r,
  output reg [23:0] vector_addr_r,
  output reg isr_load_r,
  output reg ret_pc_valid_r,
  output reg [23:0] ret_pc_r,
  output reg [3:0] cpu_level_r,
  output reg adc_conv_req_r
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer states

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_E2 = 7'h02;
localparam [6:0] S_E3 = 7'h04;
localparam [6:0] S_E4 = 7'h08;
localparam [6:0] S_R2 = 7'h10;
localparam [6:0] S_R3 = 7'h20;
localparam [6:0] S_SPARE = 7'h40;

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [`CIS_NSRC-1:0] request_flag_regs_r;
reg [`CIS_NSRC-1:0] source_enable_regs_r;
reg [`CIS_PRIO_W-1:0] source_priority_regs_r;
reg nesting_disable_r;
reg [`CIS_NEXT-1:0] external_edge_polarity_bits_r;
reg [7:0] status_low_byte_r;
reg priority_level_msb_r;
reg [6:0] state_r;
reg [6:0] state_nxt;
reg [2:0] accept_vec_r;
reg [2:0] accept_prio_r;
reg [23:0] temp_pc_r;
reg [7:0] temp_srl_r;
reg temp_msb_r;
reg [7:0] ret_hi_r;

wire [2:0] cpu_priority_field;
wire [3:0] eff_level;
wire [`CIS_NEXT-1:0] ext_edge;
wire [`CIS_NSRC-1:0] src_event;
wire [`CIS_NSRC-1:0] armed;

assign cpu_priority_field = status_low_byte_r[`CIS_IPL_HI:`CIS_IPL_LO];
assign eff_level = {priority_level_msb_r, cpu_priority_field};

////////////////////////////////////////////////////////////////////////////////
// External pin edge detection

genvar gi;
generate
  for (gi = 0; gi < `CIS_NEXT; gi = gi + 1)
  begin : g_ext
    cis_edge_detect u_edge
    (
      .core_clk(core_clk),
      .reset(reset),
      .core_ce(core_ce),
      .pin(ext_int_pin[gi]),
      .falling(external_edge_polarity_bits_r[gi]),
      .edge_seen(ext_edge[gi])
    );
  end
endgenerate

// Events on the edge are latched at the cycle end, so flags show next cycle
assign src_event = {periph_event, ext_edge};

////////////////////////////////////////////////////////////////////////////////
// Arbitration

// Pending, enabled and priority non-zero
function [`CIS_NSRC-1:0] arm_fn;
  input [`CIS_NSRC-1:0] fl;
  input [`CIS_NSRC-1:0] en;
  input [`CIS_PRIO_W-1:0] pr;
  integer k;
  begin
    arm_fn = {`CIS_NSRC{1'b0}};
    for (k = 0; k < `CIS_NSRC; k = k + 1)
      arm_fn[k] = fl[k] & en[k] & (pr[3*k +: 3] != 3'h0);
  end
endfunction

assign armed = arm_fn(request_flag_regs_r, source_enable_regs_r, source_priority_regs_r);

reg win_valid;
reg [2:0] win_vec;
reg [2:0] win_prio;
integer j;

always @*
begin
  win_valid = 1'b0;
  win_vec = 3'h0;
  win_prio = 3'h0;
  // Descending scan; >= lets the lower vector win ties
  for (j = `CIS_NSRC - 1; j >= 0; j = j - 1)
  begin
    if (armed[j] && (!win_valid || source_priority_regs_r[3*j +: 3] >= win_prio))
    begin
      win_valid = 1'b1;
      win_vec = j[2:0];
      win_prio = source_priority_regs_r[3*j +: 3];
    end
  end
end

// Only a level strictly above the current one is presented
wire present = win_valid && ({1'b0, win_prio} > eff_level);

////////////////////////////////////////////////////////////////////////////////
// Sequencer

always @*
begin
  state_nxt = state_r;
  case (state_r)
    S_IDLE:
    begin
      if (ret_start)
        state_nxt = S_R2;
      else if (present)
        state_nxt = S_E2;
    end
    S_E2: state_nxt = S_E3;
    S_E3: state_nxt = S_E4;
    S_E4: state_nxt = S_IDLE;
    S_R2: state_nxt = S_R3;
    S_R3: state_nxt = S_IDLE;
    default: state_nxt = S_IDLE;
  endcase
end

always @(posedge core_clk)
begin
  if (reset)
  begin
    state_r <= S_IDLE;
    accept_vec_r <= 3'h0;
    accept_prio_r <= 3'h0;
    temp_pc_r <= 24'h000000;
    temp_srl_r <= 8'h00;
    temp_msb_r <= 1'b0;
    ret_hi_r <= 8'h00;
    forced_no_operation_r <= 1'b0;
    push_valid_r <= 1'b0;
    push_data_r <= 16'h0000;
    vector_load_r <= 1'b0;
    vector_addr_r <= 24'h000000;
    isr_load_r <= 1'b0;
    ret_pc_valid_r <= 1'b0;
    ret_pc_r <= 24'h000000;
    resume_r <= 1'b0;
  end
  else if (core_ce)
  begin
    state_r <= state_nxt;
    forced_no_operation_r <= (state_nxt == S_E2) || (state_nxt == S_E4);
    push_valid_r <= (state_nxt == S_E3) || (state_nxt == S_E4);
    vector_load_r <= (state_nxt == S_E3);
    isr_load_r <= (state_nxt == S_E4);
    ret_pc_valid_r <= (state_nxt == S_R3);
    resume_r <= (state_r == S_IDLE) && cpu_sleep && !ret_start && !present
      && (|armed);
    // Cycle 1: accept and save return state into the temporary buffer
    if (state_r == S_IDLE && state_nxt == S_E2)
    begin
      accept_vec_r <= win_vec;
      accept_prio_r <= win_prio;
      temp_pc_r <= cpu_pc;
      temp_srl_r <= status_low_byte_r;
      temp_msb_r <= priority_level_msb_r;
    end
    if (state_nxt == S_E3)
    begin
      vector_addr_r <= `CIS_VEC_BASE + {20'h00000, accept_vec_r, 1'b0};
      push_data_r <= temp_pc_r[15:0];
    end
    if (state_nxt == S_E4)
      push_data_r <= {temp_srl_r, temp_msb_r, temp_pc_r[22:16]};
    // Return: first pop holds status byte, msb and high PC bits
    if (state_r == S_IDLE && ret_start)
      ret_hi_r <= pop_data[7:0];
    if (state_r == S_R2)
      ret_pc_r <= {1'b0, ret_hi_r[6:0], pop_data};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, then the access completes

wire access = (avs_read || avs_write) && avs_waitrequest;
wire wr_now = avs_write && !avs_waitrequest;
wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
wire [31:0] wmask = wr_now ? bmask : 32'h00000000;
wire [31:0] wbits = avs_writedata & wmask;

reg [31:0] rd_mux;

always @*
begin
  case (avs_address)
    `CIS_OFF_FLAG: rd_mux = {24'h000000, request_flag_regs_r};
    `CIS_OFF_ENABLE: rd_mux = {24'h000000, source_enable_regs_r};
    `CIS_OFF_PRIO: rd_mux = {8'h00, source_priority_regs_r};
    `CIS_OFF_CTRL1: rd_mux = {16'h0000, nesting_disable_r, 15'h0000};
    `CIS_OFF_CTRL2: rd_mux = {27'h0000000, external_edge_polarity_bits_r};
    `CIS_OFF_STATUS: rd_mux = {24'h000000, status_low_byte_r};
    `CIS_OFF_CORE: rd_mux = {28'h0000000, priority_level_msb_r, 3'h0};
    `CIS_OFF_SEQ: rd_mux = {17'h00000, state_r, 1'b0, accept_prio_r, 1'b0, accept_vec_r};
    default: rd_mux = 32'h00000000;
  endcase
end

always @(posedge core_clk)
begin
  if (reset)
  begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h00000000;
  end
  else if (core_ce)
  begin
    if (access)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_mux : 32'h00000000;
    end
    else
      avs_waitrequest <= 1'b1;
  end
end

wire sel_flag = (avs_address == `CIS_OFF_FLAG);
wire sel_en = (avs_address == `CIS_OFF_ENABLE);
wire sel_prio = (avs_address == `CIS_OFF_PRIO);
wire sel_c1 = (avs_address == `CIS_OFF_CTRL1);
wire sel_c2 = (avs_address == `CIS_OFF_CTRL2);
wire sel_st = (avs_address == `CIS_OFF_STATUS);

////////////////////////////////////////////////////////////////////////////////
// Control and status registers

reg [7:0] srl_nxt;

always @*
begin
  srl_nxt = status_low_byte_r;
  if (sel_st)
  begin
    srl_nxt[4:0] = (status_low_byte_r[4:0] & ~wmask[4:0]) | wbits[4:0];
    if (!nesting_disable_r)
      srl_nxt[7:5] = (status_low_byte_r[7:5] & ~wmask[7:5]) | wbits[7:5];
  end
  // Hardware updates override software in the same cycle
  if (state_r == S_E4)
    srl_nxt[7:5] = nesting_disable_r ? `CIS_IPL_MAX : accept_prio_r;
  if (state_r == S_IDLE && ret_start)
    srl_nxt = pop_data[15:8];
end

always @(posedge core_clk)
begin
  if (reset)
  begin
    request_flag_regs_r <= `CIS_FLAG_RST;
    source_enable_regs_r <= `CIS_ENABLE_RST;
    source_priority_regs_r <= `CIS_PRIO_RST;
    nesting_disable_r <= 1'b0;
    external_edge_polarity_bits_r <= `CIS_POL_RST;
    status_low_byte_r <= `CIS_SRL_RST;
    priority_level_msb_r <= 1'b0;
    wake_r <= 1'b0;
    adc_conv_req_r <= 1'b0;
    cpu_level_r <= 4'h0;
  end
  else if (core_ce)
  begin
    // Write-one clears; a new event in the same cycle wins
    request_flag_regs_r <= (request_flag_regs_r & ~(sel_flag ? wbits[7:0] : 8'h00))
      | src_event;
    if (sel_en)
      source_enable_regs_r <= (source_enable_regs_r & ~wmask[7:0]) | wbits[7:0];
    if (sel_prio)
      source_priority_regs_r <= (source_priority_regs_r & ~wmask[23:0]) | wbits[23:0];
    if (sel_c1 && wmask[`CIS_NEST_DIS_BIT])
      nesting_disable_r <= wbits[`CIS_NEST_DIS_BIT];
    if (sel_c2)
      external_edge_polarity_bits_r <= (external_edge_polarity_bits_r & ~wmask[4:0])
        | wbits[4:0];
    status_low_byte_r <= srl_nxt;
    if (state_r == S_IDLE && ret_start)
      priority_level_msb_r <= pop_data[7];
    wake_r <= cpu_sleep && (|armed);
    adc_conv_req_r <= ext_edge[0];
    cpu_level_r <= {(state_r == S_IDLE && ret_start) ? pop_data[7] : priority_level_msb_r,
      srl_nxt[7:5]};
  end
end

endmodule // cis_top

// ==== tb/cis_core_model.sv ====
// Processor core model: program counter, software stack, return pops
`timescale 1ns/100ps
module cis_core_model
(
  input wire core_clk,
  input wire reset,
  input wire go,
  input wire push_valid_r,
  input wire [15:0] push_data_r,
  output reg [23:0] cpu_pc,
  output reg ret_start,
  output reg [15:0] pop_data
);
  reg [15:0] stk[$];
  reg pend_r;
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cpu_pc <= 24'h000200;
      ret_start <= 1'b0;
      pop_data <= 16'h0000;
      pend_r <= 1'b0;
    end
    else
    begin
      cpu_pc <= cpu_pc + 24'h000002;
      ret_start <= go;
      pend_r <= go;
      if (push_valid_r)
        stk.push_back(push_data_r);
      if (go || pend_r)
        pop_data <= stk.pop_back();
      else
        pop_data <= ~pop_data;
    end
  end
endmodule // cis_core_model

// ==== tb/cis_chk.sv ====
// Concurrent checks on the interrupt sequencer ports
`timescale 1ns/100ps
module cis_chk
(
  input wire core_clk,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire cpu_sleep,
  input wire ret_start,
  input wire wake_r,
  input wire resume_r,
  input wire forced_no_operation_r,
  input wire push_valid_r,
  input wire vector_load_r,
  input wire [23:0] vector_addr_r,
  input wire isr_load_r,
  input wire ret_pc_valid_r,
  input wire [3:0] cpu_level_r,
  input wire adc_conv_req_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_entry_order: assert property (forced_no_operation_r && !isr_load_r |=>
    vector_load_r && push_valid_r ##1 isr_load_r && forced_no_operation_r && push_valid_r)
    else $error("entry order broken");
  chk_vec_range: assert property (vector_load_r |-> !vector_addr_r[0] &&
    vector_addr_r >= 24'h000100 && vector_addr_r <= 24'h00010E) else $error("bad vector");
  chk_forced_no_operation_lead: assert property (vector_load_r |-> $past(forced_no_operation_r))
    else $error("vector load without forced nop");
  chk_level_set: assert property (isr_load_r |=> cpu_level_r[2:0] != 3'h0)
    else $error("level not raised");
  chk_ret_lat: assert property (ret_pc_valid_r |-> $past(ret_start, 2))
    else $error("return pc timing");
  chk_adc_pulse: assert property (adc_conv_req_r |=> !adc_conv_req_r)
    else $error("converter request too long");
  chk_wake_cause: assert property (wake_r || resume_r |-> $past(cpu_sleep))
    else $error("wake while awake");
  cov_entry: cover property (isr_load_r);
  cov_ret: cover property (ret_pc_valid_r);
  cov_resume: cover property (resume_r);
  cov_adc: cover property (adc_conv_req_r);
endmodule // cis_chk
bind cis_top cis_chk u_chk (.core_clk, .reset, .avs_read, .avs_write, .avs_waitrequest,
  .cpu_sleep, .ret_start, .wake_r, .resume_r, .forced_no_operation_r, .push_valid_r, .vector_load_r,
  .vector_addr_r, .isr_load_r, .ret_pc_valid_r, .cpu_level_r, .adc_conv_req_r);

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt sequencer
`timescale 1ns/100ps
module tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg [4:0] ext_int_pin = 5'h00;
  reg [2:0] periph_event = 3'h0;
  reg cpu_sleep = 1'b0;
  reg go = 1'b0;
  reg core_ce = 1'b1;
  wire [31:0] avs_readdata;
  wire [23:0] cpu_pc, vector_addr_r, ret_pc_r;
  wire [15:0] pop_data, push_data_r;
  wire [3:0] cpu_level_r;
  wire avs_waitrequest, ret_start, wake_r, resume_r, forced_no_operation_r, push_valid_r;
  wire vector_load_r, isr_load_r, ret_pc_valid_r, adc_conv_req_r;
  integer num_errors = 0, comparisons = 0, seed = 32'h609B22AF, lvl = 0, adc_n = 0, i;
  reg [31:0] r;
  reg [23:0] pcs[$];
  integer lvs[$];
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (adc_conv_req_r === 1'b1) adc_n <= adc_n + 1;
  cis_top DUT (.core_clk, .reset, .core_ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ext_int_pin,
    .periph_event, .cpu_pc, .cpu_sleep, .ret_start, .pop_data, .wake_r, .resume_r, .forced_no_operation_r,
    .push_valid_r, .push_data_r, .vector_load_r, .vector_addr_r, .isr_load_r,
    .ret_pc_valid_r, .ret_pc_r, .cpu_level_r, .adc_conv_req_r);
  cis_core_model u_core (.core_clk, .reset, .go, .push_valid_r, .push_data_r, .cpu_pc,
    .ret_start, .pop_data);
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e)
      begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wt;
    integer n;
    begin
      n = 0;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
        n = n + 1;
        @(posedge core_clk);
      end
      if (n >= 20) chk("wait", 1, 0);
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wt;
      avs_write <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [31:0] e);
    begin
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wt;
      r = avs_readdata;
      avs_read <= 1'b0;
      chk("rd", r, e);
    end
  endtask
  task pulse(input [2:0] b);
    begin
      @(posedge core_clk);
      periph_event <= b;
      @(posedge core_clk);
      periph_event <= 3'h0;
    end
  endtask
  // Event, then the four entry cycles
  task fire(input [2:0] b, input integer v, input integer np);
    reg [23:0] pc;
    begin
      pulse(b);
      #1 pc = cpu_pc;
      @(posedge core_clk);
      #1 chk("forced_no_operation", forced_no_operation_r, 1);
      @(posedge core_clk);
      #1 chk("vec", vector_addr_r, 24'h000100 + 2 * v);
      chk("vload", vector_load_r, 1);
      chk("pushv", push_valid_r, 1);
      chk("pushlo", push_data_r, pc[15:0]);
      @(posedge core_clk);
      #1 chk("isr", isr_load_r, 1);
      chk("pushhi", push_data_r, {lvl[2:0], 6'h00, pc[22:16]});
      @(posedge core_clk);
      #1 chk("lvl", cpu_level_r, np);
      pcs.push_back(pc);
      lvs.push_back(lvl);
      lvl = np;
    end
  endtask
  task ret;
    reg [23:0] pc;
    integer l;
    begin
      pc = pcs.pop_back();
      l = lvs.pop_back();
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
      #1 chk("rlvl", cpu_level_r, l);
      @(posedge core_clk);
      #1 chk("rpc", ret_pc_r, {1'b0, pc[22:0]});
      chk("rpcv", ret_pc_valid_r, 1);
      lvl = l;
    end
  endtask
  task conclude;
    begin
      $display("Counts: %0d compared, %0d bad", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000 num_errors = num_errors + 1;
    conclude;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 28; i = i + 4)
      rd(i, 0);
    r = $random(seed);
    wr(5'h04, r);
    rd(5'h04, r & 32'hFF);
    r = $random(seed);
    wr(5'h08, r);
    rd(5'h08, r & 32'hFFFFFF);
    $display("Test registers done");
    wr(5'h04, 32'hE0);
    wr(5'h08, 32'hD10000);
    fire(3'h1, 5, 2);
    fire(3'h2, 6, 4);
    fire(3'h4, 7, 6);
    rd(5'h00, 32'hE0);
    wr(5'h00, 32'hE0);
    rd(5'h00, 0);
    repeat (3) ret;
    wr(5'h08, 32'hD8000);
    fire(3'h3, 5, 3);
    rd(5'h00, 32'h60);
    wr(5'h00, 32'hFF);
    ret;
    $display("Test nesting done");
    wr(5'h0C, 32'h8000);
    wr(5'h08, 32'hD10000);
    fire(3'h1, 5, 7);
    wr(5'h14, 0);
    rd(5'h14, 32'hE0);
    pulse(3'h4);
    rd(5'h00, 32'hA0);
    wr(5'h00, 32'hFF);
    ret;
    wr(5'h0C, 0);
    $display("Test nesting off done");
    wr(5'h14, 32'hE0);
    lvl = 7;
    wr(5'h08, 0);
    cpu_sleep <= 1'b1;
    pulse(3'h1);
    rd(5'h00, 32'h20);
    #1 chk("wake0", wake_r, 0);
    wr(5'h08, 32'h8000);
    repeat (2) @(posedge core_clk);
    #1 chk("wake", wake_r, 1);
    chk("resume", resume_r, 1);
    @(posedge core_clk);
    cpu_sleep <= 1'b0;
    wr(5'h00, 32'hFF);
    wr(5'h14, 0);
    lvl = 0;
    $display("Test wake done");
    wr(5'h04, 0);
    wr(5'h10, 32'h02);
    @(posedge core_clk);
    ext_int_pin <= 5'h1F;
    repeat (4) @(posedge core_clk);
    rd(5'h00, 32'h1D);
    chk("adc", adc_n, 1);
    wr(5'h00, 32'hFF);
    @(posedge core_clk);
    ext_int_pin <= 5'h00;
    repeat (4) @(posedge core_clk);
    rd(5'h00, 32'h02);
    chk("adc", adc_n, 1);
    // Events while the clock enable is low must leave the flags alone
    core_ce <= 1'b0;
    pulse(3'h7);
    @(posedge core_clk);
    core_ce <= 1'b1;
    rd(5'h00, 32'h02);
    $display("Test pins done");
    conclude;
  end
endmodule // tb
